/* File: hdl/dtm_pkg.sv */
// Constants, register map and types of the dual temperature monitor core.
// Functional notes
// RULE_01 - Either bus line low beyond the timeout resets the slave and releases data.
// RULE_02 - Local reading compares with the shared local limit; masks gate both alerts.
// RULE_03 - Remote reading compares with its own critical and overtemp limits, masked.
// RULE_04 - Status register one shows comparison results whether or not alerts are masked.
// RULE_05 - Both alert outputs are open-drain, pulled low only while asserted.
// RULE_06 - With the filter on, comparisons use the filtered remote reading.
// RULE_07 - Standby stops periodic conversions; the bus slave keeps working.
// RULE_08 - In standby a one-shot write runs one full round; data is dropped.
// RULE_09 - Readings are left-justified 16-bit words in two byte registers.
// RULE_10 - Remote reading offered at once as 13-bit unsigned and signed.
// RULE_11 - Lowest two remote bits read zero unless the filter is on.
// RULE_12 - Limits are unsigned whole degrees: local 7 bits, remote 8 bits.
// RULE_13 - Busy bit seven of status one is high only during conversion.
// RULE_14 - Local and remote conversions alternate; registers update after each round; the local reading updates when its channel ends.
// RULE_15 - Rate setting only adds idle time; a round converts within 72 ms.
// RULE_16 - Readings show zero degrees until the first round completes; the local reading updates when its first channel ends.
// RULE_17 - Reset values: pointer 00h, rate 02h, limits 55h/55h/6Eh, offsets 00h.
// RULE_18 - Configuration one resets to 00h: converting, all masks clear.
// RULE_19 - Configuration two resets to 1Fh: filter on, pin is address input.
// RULE_20 - Slave only: clock is never driven or stretched, only data driven.
// RULE_21 - One 7-bit slave address chosen by a three-level address pin.
// RULE_22 - Addresses 18h, 29h, 4Ch; only 4Ch when the pin drives overtemp.
// RULE_23 - Filter code 00 is off, 11 on; 01 and 10 are reserved.
// RULE_24 - Readings may be read any time and give the last completed result.
// RULE_25 - Alerts OR all unmasked hits; release uses the shared hysteresis.
package dtm_pkg;
    // Read offsets.
    localparam logic [7:0] OFS_LOCAL_MSB  = 8'h00;
    localparam logic [7:0] OFS_LOCAL_LSB  = 8'h10;
    localparam logic [7:0] OFS_RSGN_MSB   = 8'h01;
    localparam logic [7:0] OFS_RSGN_LSB   = 8'h11;
    localparam logic [7:0] OFS_RUNS_MSB   = 8'h31;
    localparam logic [7:0] OFS_RUNS_LSB   = 8'h32;
    localparam logic [7:0] OFS_STATUS_ONE = 8'h02;
    localparam logic [7:0] OFS_CFG_ONE_RD = 8'h03;
    localparam logic [7:0] OFS_RATE_RD    = 8'h04;
    // Write offsets; the remaining registers share one offset for both.
    localparam logic [7:0] OFS_CFG_ONE_WR = 8'h09;
    localparam logic [7:0] OFS_RATE_WR    = 8'h0a;
    localparam logic [7:0] OFS_ONE_SHOT   = 8'h0f;
    localparam logic [7:0] OFS_R_OVT_LIM  = 8'h07;
    localparam logic [7:0] OFS_R_CRIT_LIM = 8'h19;
    localparam logic [7:0] OFS_L_LIM      = 8'h20;
    localparam logic [7:0] OFS_HYST       = 8'h21;
    localparam logic [7:0] OFS_OFFS_HI    = 8'h14;
    localparam logic [7:0] OFS_OFFS_LO    = 8'h15;
    localparam logic [7:0] OFS_CFG_TWO    = 8'hbf;
    // Reset values.
    localparam logic [7:0] RST_POINTER    = 8'h00;
    localparam logic [7:0] RST_RATE       = 8'h02;
    localparam logic [7:0] RST_R_OVT_LIM  = 8'h55;
    localparam logic [6:0] RST_L_LIM      = 7'h55;
    localparam logic [7:0] RST_R_CRIT_LIM = 8'h6e;
    localparam logic [7:0] RST_OFFS       = 8'h00;
    localparam logic [7:0] RST_CFG_ONE    = 8'h00;
    localparam logic [7:0] RST_CFG_TWO    = 8'h1f;
    localparam logic [7:0] RST_HYST       = 8'h0a;
    // Configuration one bits (mask set means the alert ignores that hit).
    localparam int CF1_L_CRIT_MASK = 0;
    localparam int CF1_L_OVT_MASK  = 2;
    localparam int CF1_R_OVT_MASK  = 3;
    localparam int CF1_R_CRIT_MASK = 4;
    localparam int CF1_STANDBY     = 6;
    // Configuration two bits.
    localparam int CF2_PIN_IS_ADDR = 0;
    localparam int CF2_FILTER_LO   = 1;
    localparam int CF2_FILTER_HI   = 2;
    // Slave addresses for the three address pin levels.
    localparam logic [6:0] ADDR_LOW  = 7'h18;
    localparam logic [6:0] ADDR_MID  = 7'h29;
    localparam logic [6:0] ADDR_HIGH = 7'h4c;
    localparam logic [1:0] PIN_LOW   = 2'h0;
    localparam logic [1:0] PIN_MID   = 2'h1;
    // Times and derived cycle counts at a 10 MHz clock.
    localparam int CLK_KHZ    = 10000;
    localparam int TIMEOUT_MS = 25;
    localparam int CONV_MS    = 72;
    localparam int ROUND_MS   = 1000;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
    localparam int CONV_CYC    = CONV_MS * CLK_KHZ;
    localparam int ROUND_CYC   = ROUND_MS * CLK_KHZ;

    typedef enum logic [5:0] {
        SB_IDLE  = 6'h01, SB_ADDR = 6'h02, SB_ACK   = 6'h04,
        SB_RX    = 6'h08, SB_TX   = 6'h10, SB_TXACK = 6'h20
    } dtm_bus_state_t;

    typedef enum logic [2:0] {
        SQ_IDLE = 3'h1, SQ_LOCAL = 3'h2, SQ_REMOTE = 3'h4
    } dtm_seq_state_t;

    // Comparison results, kept together because status and alerts share them.
    typedef struct packed {
        logic local_hit;
        logic rem_crit_hit;
        logic rem_ovt_hit;
    } dtm_hits_t;
endpackage : dtm_pkg

/* File: hdl/dtm_core.sv */
// Bus slave, register file, conversion sequencer and alert logic.
`timescale 1ns/1ps
`default_nettype none
module dtm_core
    import dtm_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int CONV_CYCLES    = CONV_CYC,
    parameter int ROUND_CYCLES   = ROUND_CYC
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe,
    input  wire logic [1:0]         address_select_pin,
    input  wire logic signed [10:0] local_sample,
    input  wire logic signed [13:0] remote_sample,
    output logic                    frontend_en,
    output logic                    critical_alert_oe,
    output logic                    overtemp_alert_oe
);
    localparam int CONV_HALF = CONV_CYCLES / 2;

    // Pin synchronisers; stage three only feeds the edge detectors.
    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    logic [1:0] pin_s1, pin_s2;
    always_ff @(posedge clk) begin
        scl_s1 <= scl_in;
        scl_s2 <= scl_s1;
        scl_s3 <= scl_s2;
        sda_s1 <= sda_in;
        sda_s2 <= sda_s1;
        sda_s3 <= sda_s2;
        pin_s1 <= address_select_pin;
        pin_s2 <= pin_s1;
    end

    wire scl_rise  = scl_s2 & ~scl_s3;
    wire scl_fall  = ~scl_s2 & scl_s3;
    wire bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    wire bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

    // Registers written by the host.
    logic [7:0] cfg_one, cfg_two, rate, r_ovt_lim, r_crit_lim, hyst;
    logic [7:0] offs_hi, offs_lo, pointer;
    logic [6:0] l_lim;
    logic       oneshot_req;

    // Address follows the pin live; it is not latched.
    wire pin_is_addr = cfg_two[CF2_PIN_IS_ADDR];
    wire [6:0] slave_addr = !pin_is_addr ? ADDR_HIGH :
                            (pin_s2 == PIN_LOW) ? ADDR_LOW :
                            (pin_s2 == PIN_MID) ? ADDR_MID :
                            ADDR_HIGH; // RULE_21 RULE_22

    // Stuck-line timeouts, one per line; a long run of zero bits holds data
    // low and times out even with a toggling clock. Each saturates,
    // keeping the slave idle until its line is released.
    logic [24:0] scl_lo_cnt, sda_lo_cnt;
    wire scl_to = (scl_lo_cnt == 25'(TIMEOUT_CYCLES - 1));
    wire sda_to = (sda_lo_cnt == 25'(TIMEOUT_CYCLES - 1));
    wire to_hit = scl_to | sda_to;
    always_ff @(posedge clk) begin
        if (rst || scl_s2) begin
            scl_lo_cnt <= '0;
        end else if (!scl_to) begin
            scl_lo_cnt <= scl_lo_cnt + 25'h1; // RULE_01
        end
    end
    always_ff @(posedge clk) begin
        if (rst || sda_s2) begin
            sda_lo_cnt <= '0;
        end else if (!sda_to) begin
            sda_lo_cnt <= sda_lo_cnt + 25'h1; // RULE_01
        end
    end

    // Byte level slave engine; clock is only ever sampled, never driven.
    dtm_bus_state_t sb;
    logic [3:0] bit_cnt;
    logic [7:0] shreg, txsh;
    logic       rw, first;
    logic [7:0] rd_byte;
    wire wr_stb = (sb == SB_RX) && scl_fall && (bit_cnt == 4'h8) && !first;
    always_ff @(posedge clk) begin
        if (rst) begin
            sb <= SB_IDLE;
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            txsh <= 8'h00;
            rw <= 1'b0;
            first <= 1'b0;
            pointer <= RST_POINTER; // RULE_17
        end else if (to_hit || bus_stop) begin
            sb <= SB_IDLE; // RULE_01
            sda_oe <= 1'b0; // RULE_01
        end else if (bus_start) begin
            sb <= SB_ADDR;
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
            first <= 1'b1;
        end else begin
            case (sb)
                SB_ADDR, SB_RX: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_s2};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (sb == SB_RX) begin
                            sb <= SB_ACK;
                            sda_oe <= 1'b1;
                            first <= 1'b0;
                            if (first) begin
                                pointer <= shreg;
                            end
                        end else if (shreg[7:1] == slave_addr) begin
                            sb <= SB_ACK; // RULE_21
                            sda_oe <= 1'b1;
                            rw <= shreg[0];
                        end else begin
                            sb <= SB_IDLE;
                        end
                    end
                end
                SB_ACK: begin
                    if (scl_fall && rw) begin
                        sb <= SB_TX;
                        txsh <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                        bit_cnt <= 4'h0;
                    end else if (scl_fall) begin
                        sb <= SB_RX;
                        sda_oe <= 1'b0;
                    end
                end
                SB_TX: begin
                    if (scl_fall && bit_cnt == 4'h7) begin
                        sb <= SB_TXACK;
                        sda_oe <= 1'b0;
                    end else if (scl_fall) begin
                        txsh <= {txsh[6:0], 1'b0};
                        sda_oe <= ~txsh[6];
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                SB_TXACK: begin
                    if (scl_rise) begin
                        sb <= sda_s2 ? SB_IDLE : SB_ACK;
                    end
                end
                default: sb <= SB_IDLE;
            endcase
        end
    end

    // The pin level is always low; only its enable moves.
    always_ff @(posedge clk) begin
        sda_out <= 1'b0; // RULE_20
    end

    // Host writes; read-only offsets and unmapped offsets are ignored.
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_one <= RST_CFG_ONE; // RULE_18
            cfg_two <= RST_CFG_TWO; // RULE_19
            rate <= RST_RATE;
            r_ovt_lim <= RST_R_OVT_LIM;
            r_crit_lim <= RST_R_CRIT_LIM;
            l_lim <= RST_L_LIM; // RULE_17
            hyst <= RST_HYST;
            offs_hi <= RST_OFFS;
            offs_lo <= RST_OFFS;
        end else if (wr_stb) begin
            if (pointer == OFS_CFG_ONE_WR) cfg_one <= shreg;
            if (pointer == OFS_CFG_TWO) cfg_two <= shreg;
            if (pointer == OFS_RATE_WR) rate <= shreg; // RULE_15
            if (pointer == OFS_R_OVT_LIM) r_ovt_lim <= shreg;
            if (pointer == OFS_R_CRIT_LIM) r_crit_lim <= shreg;
            if (pointer == OFS_L_LIM) l_lim <= shreg[6:0]; // RULE_12
            if (pointer == OFS_HYST) hyst <= shreg;
            if (pointer == OFS_OFFS_HI) offs_hi <= shreg;
            if (pointer == OFS_OFFS_LO) offs_lo <= shreg;
        end
    end

    // Conversion sequencer.
    dtm_seq_state_t sq;
    logic [18:0] conv_cnt;
    logic [25:0] round_cnt;
    logic signed [10:0] local_temp;
    logic signed [13:0] rem_temp, filt;
    logic       upd;
    dtm_hits_t  hits;
    wire standby = cfg_one[CF1_STANDBY];
    wire filt_on = cfg_two[CF2_FILTER_HI] & cfg_two[CF2_FILTER_LO]; // RULE_23
    wire [25:0] period = 26'(ROUND_CYCLES * 4) >> rate[1:0];
    wire ch_done = (conv_cnt == 19'(CONV_HALF - 1));
    wire go = (sq == SQ_IDLE) &&
              (oneshot_req || (!standby && round_cnt >= period)); // RULE_07
    wire oneshot_wr = wr_stb && (pointer == OFS_ONE_SHOT) && standby;
    wire signed [14:0] fdiff = 15'(remote_sample) - 15'(filt);
    wire signed [13:0] filt_next = filt + 14'(fdiff >>> 2);

    // A one-shot write landing with go still wins the next round.
    always_ff @(posedge clk) begin
        if (rst) begin
            oneshot_req <= 1'b0;
        end else begin
            oneshot_req <= oneshot_wr | (oneshot_req & ~go); // RULE_08
        end
    end

    // First round starts right after reset; round counter saturates.
    always_ff @(posedge clk) begin
        if (rst) begin
            sq <= SQ_IDLE;
            conv_cnt <= '0;
            round_cnt <= '1;
        end else begin
            conv_cnt <= (sq == SQ_IDLE || ch_done) ? '0 : conv_cnt + 19'h1;
            if (go) round_cnt <= '0;
            else if (round_cnt != '1) round_cnt <= round_cnt + 26'h1;
            case (sq)
                SQ_IDLE: if (go) sq <= SQ_LOCAL; // RULE_08
                SQ_LOCAL: if (ch_done) sq <= SQ_REMOTE; // RULE_14
                SQ_REMOTE: if (ch_done) sq <= SQ_IDLE; // RULE_15
                default: sq <= SQ_IDLE;
            endcase
        end
    end

    // Results land at the end of each channel; zero until the first one.
    always_ff @(posedge clk) begin
        if (rst) begin
            local_temp <= '0; // RULE_16
            rem_temp <= '0; // RULE_16
            filt <= '0;
            upd <= 1'b0;
        end else begin
            upd <= (sq == SQ_REMOTE) && ch_done; // RULE_14
            if (sq == SQ_LOCAL && ch_done) local_temp <= local_sample;
            if (sq == SQ_REMOTE && ch_done) begin
                filt <= filt_on ? filt_next : remote_sample;
                rem_temp <= filt_on ? filt_next
                          : {remote_sample[13:2], 2'b00}; // RULE_06 RULE_11
            end
        end
    end

    // Hysteresis comparison: set above limit, clear at limit minus hyst.
    function automatic logic hit_f(input logic signed [9:0] t,
                                   input logic [7:0] lim,
                                   input logic was);
        logic signed [9:0] thr;
        thr = was ? 10'({2'b00, lim}) - 10'({2'b00, hyst})
                  : 10'({2'b00, lim});
        return t > thr;
    endfunction : hit_f

    // Whole degrees with the sign carried, so cold readings stay negative.
    wire signed [9:0] loc_deg = {{2{local_temp[10]}}, local_temp[10:3]};
    wire signed [9:0] rem_deg = {rem_temp[13], rem_temp[13:5]};

    always_ff @(posedge clk) begin
        if (rst) begin
            hits <= '0;
        end else if (upd) begin
            hits.local_hit <= hit_f(loc_deg, {1'b0, l_lim},
                                    hits.local_hit); // RULE_02 RULE_25
            hits.rem_crit_hit <= hit_f(rem_deg, r_crit_lim,
                                       hits.rem_crit_hit); // RULE_03
            hits.rem_ovt_hit <= hit_f(rem_deg, r_ovt_lim,
                                      hits.rem_ovt_hit); // RULE_03 RULE_06
        end
    end

    // Alerts OR the unmasked hits, overtemp only while the pin is not the address input; pins are pulled low by raising enables.
    wire crit_on = (hits.local_hit & ~cfg_one[CF1_L_CRIT_MASK]) |
                   (hits.rem_crit_hit & ~cfg_one[CF1_R_CRIT_MASK]); // RULE_25
    wire ovt_on = (hits.local_hit & ~cfg_one[CF1_L_OVT_MASK]) |
                  (hits.rem_ovt_hit & ~cfg_one[CF1_R_OVT_MASK]); // RULE_25
    always_ff @(posedge clk) begin
        if (rst) begin
            critical_alert_oe <= 1'b0;
            overtemp_alert_oe <= 1'b0;
            frontend_en <= 1'b0;
        end else begin
            critical_alert_oe <= crit_on; // RULE_05
            overtemp_alert_oe <= ovt_on & ~pin_is_addr; // RULE_05 RULE_22
            frontend_en <= (sq != SQ_IDLE) || go; // RULE_07
        end
    end

    // Read formats: signed clamps above 127.97 C, unsigned clamps below 0 C.
    wire [12:0] rem_sgn = (!rem_temp[13] && rem_temp[12]) ? 13'h0fff
                          : rem_temp[12:0];
    wire [12:0] rem_uns = rem_temp[13] ? 13'h0000 : rem_temp[12:0];
    wire [7:0] status_byte = {sq != SQ_IDLE, 2'b00, hits.rem_crit_hit,
                              hits.rem_ovt_hit, 2'b00, hits.local_hit};
    assign rd_byte =
        (pointer == OFS_LOCAL_MSB)  ? local_temp[10:3] :
        (pointer == OFS_LOCAL_LSB)  ? {local_temp[2:0], 5'h00} : // RULE_09
        (pointer == OFS_RSGN_MSB)   ? rem_sgn[12:5] :
        (pointer == OFS_RSGN_LSB)   ? {rem_sgn[4:0], 3'h0} : // RULE_10
        (pointer == OFS_RUNS_MSB)   ? rem_uns[12:5] :
        (pointer == OFS_RUNS_LSB)   ? {rem_uns[4:0], 3'h0} : // RULE_24
        (pointer == OFS_STATUS_ONE) ? status_byte : // RULE_04 RULE_13
        (pointer == OFS_CFG_ONE_RD) ? cfg_one :
        (pointer == OFS_RATE_RD)    ? rate :
        (pointer == OFS_CFG_TWO)    ? cfg_two :
        (pointer == OFS_R_OVT_LIM)  ? r_ovt_lim :
        (pointer == OFS_R_CRIT_LIM) ? r_crit_lim :
        (pointer == OFS_L_LIM)      ? {1'b0, l_lim} :
        (pointer == OFS_HYST)       ? hyst :
        (pointer == OFS_OFFS_HI)    ? offs_hi :
        (pointer == OFS_OFFS_LO)    ? offs_lo : 8'h00;

    // Checks on the behaviour above.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    timeout_release_a: assert property ( // RULE_01
        to_hit |=> (sb == SB_IDLE) && !sda_oe)
        else $error("Slave not released after bus timeout.");
    local_crit_a: assert property ( // RULE_02
        hits.local_hit && !cfg_one[CF1_L_CRIT_MASK] |=> critical_alert_oe)
        else $error("Local hit did not pull critical alert.");
    remote_ovt_a: assert property ( // RULE_03
        hits.rem_ovt_hit && !cfg_one[CF1_R_OVT_MASK] && !pin_is_addr
        |=> overtemp_alert_oe)
        else $error("Remote overtemp hit did not pull alert.");
    status_mirror_a: assert property ( // RULE_04
        pointer == OFS_STATUS_ONE |-> rd_byte[4] == hits.rem_crit_hit &&
        rd_byte[3] == hits.rem_ovt_hit && rd_byte[0] == hits.local_hit)
        else $error("Status does not mirror comparison results.");
    alert_release_a: assert property ( // RULE_05
        !crit_on && !ovt_on |=> !critical_alert_oe && !overtemp_alert_oe)
        else $error("Alert held low without an unmasked hit.");
    standby_halt_a: assert property ( // RULE_07
        sq == SQ_IDLE && standby && !oneshot_req ##1 standby && !oneshot_req
        |-> sq == SQ_IDLE)
        else $error("Conversion started in standby without one-shot.");
    oneshot_start_a: assert property ( // RULE_08
        oneshot_wr |=> ##[0:1] sq == SQ_LOCAL)
        else $error("One-shot write did not start a round.");
    filter_zero_a: assert property ( // RULE_11
        sq == SQ_REMOTE && ch_done && !filt_on |=> rem_temp[1:0] == 2'b00)
        else $error("Low remote bits set with filter off.");
    busy_flag_a: assert property ( // RULE_13
        status_byte[7] == (sq == SQ_LOCAL || sq == SQ_REMOTE))
        else $error("Busy flag disagrees with conversion state.");
    round_order_a: assert property ( // RULE_14
        sq == SQ_LOCAL && ch_done |=> sq == SQ_REMOTE ##0 $stable(rem_temp))
        else $error("Remote conversion did not follow local.");

    round_done_c: cover property (upd);
    oneshot_c: cover property (oneshot_wr);
    timeout_c: cover property (to_hit);
    addr_ack_c: cover property (sb == SB_ADDR ##1 sb == SB_ACK);
endmodule : dtm_core
`default_nettype wire

/* File: bench/dtm_host_model.sv */
// Bus host model that drives the clock line and pulls the data line.
`timescale 1ns/1ps
`default_nettype none
module dtm_host_model (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      pull
);
    localparam int Q = 6;
    // Clock driven high and data released at time zero; the pull-up makes idle data high.
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    task automatic w;
        repeat (Q) @(posedge clk);
    endtask : w
    // Data moves only while the clock is low and is read mid-high.
    task automatic bitx(input logic b, output logic r);
        pull <= ~b;
        w();
        scl <= 1'b1;
        w();
        r = sda_line;
        w();
        scl <= 1'b0;
        w();
    endtask : bitx
    // Serves as a first start and as a repeated start alike.
    task automatic start;
        pull <= 1'b0;
        w();
        scl <= 1'b1;
        w();
        pull <= 1'b1;
        w();
        scl <= 1'b0;
        w();
    endtask : start
    task automatic stop;
        pull <= 1'b1;
        w();
        scl <= 1'b1;
        w();
        pull <= 1'b0;
        w();
    endtask : stop
    task automatic send(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(v[i], r);
        bitx(1'b1, r);
        ack = (r === 1'b0);
    endtask : send
    // Reads one byte and answers with a not-acknowledge to end the read.
    task automatic recv(output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            v[i] = r;
        end
        bitx(1'b1, r);
    endtask : recv
endmodule : dtm_host_model
`default_nettype wire

/* File: bench/dtm_core_tb_top.sv */
// Self-checking bench of the dual temperature monitor core.
`timescale 1ns/1ps
`default_nettype none
module dtm_core_tb_top
    import dtm_pkg::*;
;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic [1:0]         pin = 2'h2;
    logic signed [10:0] loc = '0;
    logic signed [13:0] rem = '0;
    wire logic          scl, pull, sda, sda_oe, fe_en, crit_oe, ovt_oe;
    integer             seed = 83314;
    int                 mismatches = 0;
    int                 samples_checked = 0;
    int                 cyc = 0;
    logic [7:0]         d;
    logic               a;
    logic [15:0]        lw;
    logic [15:0]        rw;
    logic [7:0] ofs [9] = '{8'h04, 8'h03, 8'hbf, 8'h20, 8'h19, 8'h07,
                            8'h14, 8'h15, 8'hfe};
    logic [7:0] val [9] = '{8'h02, 8'h00, 8'h1f, 8'h55, 8'h6e, 8'h55,
                            8'h00, 8'h00, 8'h00};
    logic [6:0] adr [3] = '{ADDR_LOW, ADDR_MID, ADDR_HIGH};
    // Wired-AND data line with its pull-up.
    assign sda = !(sda_oe | pull);
    always #50 clk = ~clk;
    // The timeout must outlast the longest run of zero bits on the bus.
    dtm_core #(.TIMEOUT_CYCLES(400), .CONV_CYCLES(20), .ROUND_CYCLES(100))
    dtm_core_inst (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe(sda_oe), .address_select_pin(pin),
        .local_sample(loc), .remote_sample(rem), .frontend_en(fe_en),
        .critical_alert_oe(crit_oe), .overtemp_alert_oe(ovt_oe));
    dtm_host_model dtm_host_model_inst (.clk(clk), .sda_line(sda),
        .scl(scl), .pull(pull));
    function automatic logic [15:0] loc_word(logic [10:0] s);
        return {s, 5'h00};
    endfunction : loc_word
    // With the filter off the two finest remote bits must be zero.
    function automatic logic [15:0] rem_word(logic [13:0] s);
        return {s[12:2], 5'h00};
    endfunction : rem_word
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test;
        if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] o, input logic [7:0] v);
        dtm_host_model_inst.start();
        dtm_host_model_inst.send({ADDR_HIGH, 1'b0}, a);
        dtm_host_model_inst.send(o, a);
        dtm_host_model_inst.send(v, a);
        dtm_host_model_inst.stop();
    endtask : wr
    task automatic rd(input logic [7:0] o, output logic [7:0] v);
        dtm_host_model_inst.start();
        dtm_host_model_inst.send({ADDR_HIGH, 1'b0}, a);
        dtm_host_model_inst.send(o, a);
        dtm_host_model_inst.start();
        dtm_host_model_inst.send({ADDR_HIGH, 1'b1}, a);
        dtm_host_model_inst.recv(v);
        dtm_host_model_inst.stop();
    endtask : rd
    // A hang counts as a mismatch and ends the run.
    always @(posedge clk) begin
        cyc++;
        if (cyc > 80000) begin
            mismatches++;
            finish_test();
        end
    end
    // Main sequence of scenarios.
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            rd(ofs[i], d);
            chk(d, val[i]);
        end
        dtm_host_model_inst.start();
        dtm_host_model_inst.send({ADDR_HIGH, 1'b1}, a);
        repeat (10) @(posedge clk);
        chk(sda_oe, 1'b1);
        repeat (410) @(posedge clk);
        chk(sda_oe, 1'b0);
        dtm_host_model_inst.stop();
        for (int p = 0; p < 3; p++) begin
            pin <= p[1:0];
            for (int j = 0; j < 3; j++) begin
                dtm_host_model_inst.start();
                dtm_host_model_inst.send({adr[j], 1'b0}, a);
                dtm_host_model_inst.stop();
                chk(a, p == j);
            end
        end
        pin <= 2'h2;
        wr(OFS_CFG_TWO, 8'h19);
        for (int k = 0; k < 3; k++) begin
            loc <= 11'($random(seed));
            rem <= {2'b00, 12'($random(seed)) | 12'h003};
            repeat (250) @(posedge clk);
            lw = loc_word(loc);
            rw = rem_word(rem);
            rd(OFS_LOCAL_MSB, d);
            chk(d, lw[15:8]);
            rd(OFS_LOCAL_LSB, d);
            chk(d, lw[7:0]);
            rd(OFS_RSGN_LSB, d);
            chk(d, rw[7:0]);
            rd(OFS_RUNS_MSB, d);
            chk(d, rw[15:8]);
            rd(OFS_RUNS_LSB, d);
            chk(d, rw[7:0]);
        end
        loc <= 11'sd800;
        rem <= 14'sd2880;
        wr(OFS_CFG_TWO, 8'h18);
        repeat (250) @(posedge clk);
        rd(OFS_STATUS_ONE, d);
        chk(d & 8'h7f, 8'h09);
        chk({crit_oe, ovt_oe}, 2'b11);
        wr(OFS_CFG_ONE_WR, 8'h0d);
        chk({crit_oe, ovt_oe}, 2'b00);
        rem <= 14'sd3840;
        repeat (250) @(posedge clk);
        rd(OFS_STATUS_ONE, d);
        chk(d & 8'h7f, 8'h19);
        chk({crit_oe, ovt_oe}, 2'b10);
        wr(OFS_CFG_ONE_WR, 8'h40);
        repeat (300) @(posedge clk);
        chk(fe_en, 1'b0);
        loc <= 11'sd200;
        rd(OFS_LOCAL_MSB, d);
        chk(d, 8'h64);
        wr(OFS_ONE_SHOT, 8'($random(seed)));
        repeat (100) @(posedge clk);
        rd(OFS_LOCAL_MSB, d);
        chk(d, 8'h19);
        rd(OFS_STATUS_ONE, d);
        chk(d[7], 1'b0);
        finish_test();
    end
endmodule : dtm_core_tb_top
`default_nettype wire
